// [pkg/dmi_cfg.svh]
// Constants for the data-move instruction unit: opcodes, addressing, register map.
// Assumes an 8-bit data path, a 12-bit data space and a 32-bit AHB-Lite register bus.
//
// Summary of operation
// - Opcode 0101 00da copies file register to destination, updating N and Z.
// - Destination bit 0 writes working register; bit 1 writes back to file.
// - Cleared bank bit selects the fixed access bank.
// - Set bank bit uses bank select register to pick the register bank.
// - Extended set, bank bit 0, address up to 95: indexed literal offset.
// - Eight-bit file operand reaches any byte of the selected 256-byte bank.
// - File-to-file move: words 1100 source, 1111 destination, 12-bit, no flags.
// - Working register address is legal as file-to-file source or destination.
// - Opcode 0000 0001 loads bank select low nibble; upper nibble reads zero.
// - Opcode 0000 1110 loads literal into working register, flags unchanged.
// - Opcode 0110 111a stores working register to file, flags unchanged.
`ifndef DMI_CFG_SVH
`define DMI_CFG_SVH

// Opcode prefixes
`define DMI_OP_MFD 6'h14
`define DMI_OP_MFF1 4'hC
`define DMI_OP_MFF2 4'hF
`define DMI_OP_LLB 8'h01
`define DMI_OP_LLW 8'h0E
`define DMI_OP_SWF 7'h37

// Access bank split and page numbers
`define DMI_ACC_SPLIT 8'h60
`define DMI_ACC_LOW 4'h0
`define DMI_ACC_HIGH 4'hF

// Data-space address that aliases the working register
`define DMI_WREG_ADDR 12'hFE0

// Phase counter values, first to last
`define DMI_Q_FIRST 2'h0
`define DMI_Q_READ 2'h1
`define DMI_Q_PROC 2'h2
`define DMI_Q_LAST 2'h3

// Register map (byte addresses)
`define DMI_REG_CTRL 32'h00000000
`define DMI_REG_STAT 32'h00000004
`define DMI_REG_WREG 32'h00000008
`define DMI_REG_BANK 32'h0000000C

// Control register layout and reset value
`define DMI_CTRL_EXT_BIT 0
`define DMI_CTRL_RST 1'b0

`endif

// [pkg/dmi_pkg.sv]
// Types shared by the data-move instruction unit and its register slave.
// Assumes the constants of dmi_cfg.svh for widths of opcodes and offsets.
package dmi_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT2, ST_EXEC2} dmi_state_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_MOVE_FILE_TO_DEST,
    OP_MOVE_FILE_TO_FILE,
    OP_LOAD_LITERAL_BANK_SELECT,
    OP_LOAD_LITERAL_WORKING,
    OP_STORE_WORKING_TO_FILE
  } dmi_op_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } dmi_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } dmi_ahb_rsp_t;

  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dmi_dmem_req_t;

  typedef struct packed {
    logic busy;
    logic flag_n;
    logic flag_z;
    logic [7:0] w;
    logic [3:0] bank_select_register;
  } dmi_stat_t;

endpackage : dmi_pkg

// [verilog/dmi_ahb_regs.sv]
// AHB-Lite slave holding the unit's control bit and showing its state.
// Assumes single word transfers; always ready, always OKAY.
`timescale 1ns/1ps
`include "dmi_cfg.svh"

module dmi_ahb_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bus
  input wire dmi_pkg::dmi_ahb_req_t ahb_i,
  output dmi_pkg::dmi_ahb_rsp_t ahb_o,
  // Core side
  input wire dmi_pkg::dmi_stat_t stat_i,
  output logic ext_en_o
);

  logic ctrl_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic addr_ok;
  logic ctrl_fwd;
  logic [31:0] rd_val;

  // Address phase accepted only with hready high
  assign addr_ok = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
  // Pending write to control wins over the stored bit for a back-to-back read
  assign ctrl_fwd = (wr_pend_r && (wr_addr_r == `DMI_REG_CTRL)) ? ahb_i.hwdata[`DMI_CTRL_EXT_BIT] : ctrl_r;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h00000000;
    if (ahb_i.haddr == `DMI_REG_CTRL) begin
      rd_val[`DMI_CTRL_EXT_BIT] = ctrl_fwd;
    end else if (ahb_i.haddr == `DMI_REG_STAT) begin
      rd_val[2:0] = {stat_i.busy, stat_i.flag_n, stat_i.flag_z};
    end else if (ahb_i.haddr == `DMI_REG_WREG) begin
      rd_val[7:0] = stat_i.w;
    end else if (ahb_i.haddr == `DMI_REG_BANK) begin
      rd_val[3:0] = stat_i.bank_select_register;
    end
  end

  // Address phase capture
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_ok && ahb_i.hwrite;
      if (addr_ok) begin
        wr_addr_r <= ahb_i.haddr;
      end
      if (addr_ok && !ahb_i.hwrite) begin
        hrdata_r <= rd_val;
      end
    end
  end

  // Control write in the data phase; other offsets ignore writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `DMI_CTRL_RST;
    end else if (wr_pend_r && (wr_addr_r == `DMI_REG_CTRL)) begin
      ctrl_r <= ahb_i.hwdata[`DMI_CTRL_EXT_BIT];
    end
  end

  assign ext_en_o = ctrl_r;
  assign ahb_o.hrdata = hrdata_r;
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp = 1'b0;

endmodule : dmi_ahb_regs

// [verilog/dmi_core.sv]
// Decode and execute of the data-move instruction group.
// Assumes a synchronous data memory with one cycle read latency on the same clock,
// and FSR2 supplied by the register file on the same clock.
`timescale 1ns/1ps
`include "dmi_cfg.svh"

module dmi_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Instruction stream
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  // Data memory
  output dmi_pkg::dmi_dmem_req_t dmem_o,
  input wire logic [7:0] dmem_rdata_i,
  // Register file
  input wire logic [11:0] fsr2_i,
  // State view
  output dmi_pkg::dmi_stat_t stat_o,
  // Register bus
  input wire dmi_pkg::dmi_ahb_req_t ahb_i,
  output dmi_pkg::dmi_ahb_rsp_t ahb_o
);

  dmi_pkg::dmi_state_t state_r;
  dmi_pkg::dmi_op_t op_r;
  logic [1:0] q_r;
  logic d_r;
  logic [7:0] lit_r;
  logic [11:0] src_r;
  logic [11:0] dst_r;
  logic [7:0] data_r;
  logic [7:0] w_r;
  logic [3:0] bsr_r;
  logic n_r;
  logic z_r;
  dmi_pkg::dmi_dmem_req_t dmem_r;
  dmi_pkg::dmi_stat_t stat;
  logic ext_en;
  logic [7:0] src_val;
  logic [7:0] proc_val;
  logic wr_back;
  logic in_exec;

  // Opcode decode of a first word
  function automatic dmi_pkg::dmi_op_t f_decode(input logic [15:0] ins);
    dmi_pkg::dmi_op_t op;
    op = dmi_pkg::OP_NONE;
    if (ins[15:10] == `DMI_OP_MFD) begin
      op = dmi_pkg::OP_MOVE_FILE_TO_DEST;
    end else if (ins[15:12] == `DMI_OP_MFF1) begin
      op = dmi_pkg::OP_MOVE_FILE_TO_FILE;
    end else if (ins[15:8] == `DMI_OP_LLB) begin
      op = dmi_pkg::OP_LOAD_LITERAL_BANK_SELECT;
    end else if (ins[15:8] == `DMI_OP_LLW) begin
      op = dmi_pkg::OP_LOAD_LITERAL_WORKING;
    end else if (ins[15:9] == `DMI_OP_SWF) begin
      op = dmi_pkg::OP_STORE_WORKING_TO_FILE;
    end
    return op;
  endfunction : f_decode

  // Banked file address to data-space address
  function automatic logic [11:0] f_eff_addr(input logic [7:0] f, input logic a, input logic [3:0] bank_select_register,
                                              input logic ext, input logic [11:0] fsr2);
    logic [11:0] ea;
    if (a) begin
      ea = {bank_select_register, f};
    end else if (ext && (f < `DMI_ACC_SPLIT)) begin
      ea = fsr2 + {4'h0, f};
    end else if (f < `DMI_ACC_SPLIT) begin
      ea = {`DMI_ACC_LOW, f};
    end else begin
      ea = {`DMI_ACC_HIGH, f};
    end
    return ea;
  endfunction : f_eff_addr

  assign in_exec = (state_r == dmi_pkg::ST_EXEC);
  // Words are taken only while idle or waiting for a second word; keeps the phase sequence simple
  assign instr_ready_o = (state_r == dmi_pkg::ST_IDLE) || (state_r == dmi_pkg::ST_WAIT2);

  assign src_val = (src_r == `DMI_WREG_ADDR) ? w_r : dmem_rdata_i;

  // Value produced in the process phase
  always_comb begin
    proc_val = 8'h00;
    case (op_r)
      dmi_pkg::OP_MOVE_FILE_TO_DEST: proc_val = src_val;
      dmi_pkg::OP_MOVE_FILE_TO_FILE: proc_val = src_val;
      dmi_pkg::OP_LOAD_LITERAL_BANK_SELECT: proc_val = lit_r;
      dmi_pkg::OP_LOAD_LITERAL_WORKING: proc_val = lit_r;
      dmi_pkg::OP_STORE_WORKING_TO_FILE: proc_val = w_r;
      default: proc_val = 8'h00;
    endcase
  end

  assign wr_back = ((op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST) && d_r) || (op_r == dmi_pkg::OP_STORE_WORKING_TO_FILE);

  // Sequencer: state and phase counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= dmi_pkg::ST_IDLE;
      q_r <= `DMI_Q_FIRST;
    end else begin
      case (state_r)
        dmi_pkg::ST_IDLE: begin
          // Unknown words are consumed and ignored
          if (instr_valid_i && (f_decode(instr_i) != dmi_pkg::OP_NONE)) begin
            state_r <= dmi_pkg::ST_EXEC;
            q_r <= `DMI_Q_FIRST;
          end
        end
        dmi_pkg::ST_EXEC: begin
          q_r <= q_r + 2'h1;
          if (q_r == `DMI_Q_LAST) begin
            state_r <= (op_r == dmi_pkg::OP_MOVE_FILE_TO_FILE) ? dmi_pkg::ST_WAIT2 : dmi_pkg::ST_IDLE;
          end
        end
        dmi_pkg::ST_WAIT2: begin
          // second word needs its prefix, else the move is dropped
          if (instr_valid_i) begin
            state_r <= (instr_i[15:12] == `DMI_OP_MFF2) ? dmi_pkg::ST_EXEC2 : dmi_pkg::ST_IDLE;
            q_r <= `DMI_Q_FIRST;
          end
        end
        default: begin
          q_r <= q_r + 2'h1;
          if (q_r == `DMI_Q_LAST) begin
            state_r <= dmi_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Operand capture at decode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_r <= dmi_pkg::OP_NONE;
      d_r <= 1'b0;
      lit_r <= 8'h00;
      src_r <= 12'h000;
      dst_r <= 12'h000;
    end else if ((state_r == dmi_pkg::ST_IDLE) && instr_valid_i) begin
      op_r <= f_decode(instr_i);
      d_r <= instr_i[9];
      lit_r <= instr_i[7:0];
      if (instr_i[15:12] == `DMI_OP_MFF1) begin
        src_r <= instr_i[11:0];
      end else begin
        src_r <= f_eff_addr(instr_i[7:0], instr_i[8], bsr_r, ext_en, fsr2_i);
      end
    end else if ((state_r == dmi_pkg::ST_WAIT2) && instr_valid_i) begin
      dst_r <= instr_i[11:0];
    end
  end

  // Data memory strobes, all from flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dmem_r <= '0;
    end else begin
      dmem_r.rd <= 1'b0;
      dmem_r.wr <= 1'b0;
      if (in_exec && (q_r == `DMI_Q_FIRST)) begin
        // source read strobe, high in the second (read) phase
        if (((op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST) || (op_r == dmi_pkg::OP_MOVE_FILE_TO_FILE)) &&
            (src_r != `DMI_WREG_ADDR)) begin
          dmem_r.rd <= 1'b1;
          dmem_r.addr <= src_r;
        end
      end else if (in_exec && (q_r == `DMI_Q_PROC)) begin
        if (wr_back && (src_r != `DMI_WREG_ADDR)) begin
          dmem_r.wr <= 1'b1;
          dmem_r.addr <= src_r;
          dmem_r.wdata <= proc_val;
        end
      end else if ((state_r == dmi_pkg::ST_EXEC2) && (q_r == `DMI_Q_PROC)) begin
        // any destination but the W alias is written to data memory; W alias goes to W
        if (dst_r != `DMI_WREG_ADDR) begin
          dmem_r.wr <= 1'b1;
          dmem_r.addr <= dst_r;
          dmem_r.wdata <= data_r;
        end
      end
    end
  end

  // Process-phase latch of the moved value
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_r <= 8'h00;
    end else if (in_exec && (q_r == `DMI_Q_PROC)) begin
      data_r <= proc_val;
    end
  end

  // Working register update in the write phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_r <= 8'h00;
    end else if (in_exec && (q_r == `DMI_Q_LAST)) begin
      if (((op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST) && !d_r) || (op_r == dmi_pkg::OP_LOAD_LITERAL_WORKING) ||
          (wr_back && (src_r == `DMI_WREG_ADDR))) begin
        w_r <= data_r;
      end
    end else if ((state_r == dmi_pkg::ST_EXEC2) && (q_r == `DMI_Q_LAST) && (dst_r == `DMI_WREG_ADDR)) begin
      w_r <= data_r;
    end
  end

  // Bank select; only the low nibble exists
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bsr_r <= 4'h0;
    end else if (in_exec && (q_r == `DMI_Q_LAST) && (op_r == dmi_pkg::OP_LOAD_LITERAL_BANK_SELECT)) begin
      bsr_r <= data_r[3:0];
    end
  end

  // Negative and zero flags, touched only by the file-to-destination move
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      n_r <= 1'b0;
      z_r <= 1'b0;
    end else if (in_exec && (q_r == `DMI_Q_LAST) && (op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST)) begin
      n_r <= data_r[7];
      z_r <= (data_r == 8'h00);
    end
  end

  assign stat.busy = (state_r != dmi_pkg::ST_IDLE);
  assign stat.flag_n = n_r;
  assign stat.flag_z = z_r;
  assign stat.w = w_r;
  assign stat.bank_select_register = bsr_r;
  assign stat_o = stat;
  assign dmem_o = dmem_r;

  // Register slave
  dmi_ahb_regs u_regs (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ahb_i(ahb_i),
    .ahb_o(ahb_o),
    .stat_i(stat),
    .ext_en_o(ext_en)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_phases;
    (q_r == 2'h1) ##1 (q_r == 2'h2) ##1 (q_r == 2'h3);
  endsequence

  chk_phase_order: assert property (
    (in_exec && (q_r == 2'h0)) |=> s_phases)
    else $error("phase order broken");

  chk_flags_moved: assert property (
    (in_exec && (q_r == 2'h3) && (op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST)) |=>
      (n_r == $past(data_r[7])) && (z_r == ($past(data_r) == 8'h00)))
    else $error("flags not from moved value");

  chk_dest_working: assert property (
    (in_exec && (q_r == 2'h2) && (op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST) && !d_r) |=>
      !dmem_r.wr ##1 (w_r == $past(data_r)))
    else $error("move to W failed");

  chk_dest_file: assert property (
    (in_exec && (q_r == 2'h2) && (op_r == dmi_pkg::OP_MOVE_FILE_TO_DEST) && d_r && (src_r != 12'hFE0)) |=>
      dmem_r.wr && (dmem_r.addr == $past(src_r)) && (dmem_r.wdata == $past(src_val)))
    else $error("write back missing");

  chk_read_phase: assert property (
    (in_exec && (q_r == 2'h0) && (op_r == dmi_pkg::OP_MOVE_FILE_TO_FILE) && (src_r != 12'hFE0)) |=>
      dmem_r.rd && (dmem_r.addr == src_r) && (q_r == 2'h1))
    else $error("source read not in second phase");

  chk_no_dummy_read: assert property (
    (state_r == dmi_pkg::ST_EXEC2) |-> !dmem_r.rd)
    else $error("dummy read in second cycle");

  chk_dest_write: assert property (
    ((state_r == dmi_pkg::ST_EXEC2) && (q_r == 2'h2) && (dst_r != 12'hFE0)) |=>
      dmem_r.wr && (dmem_r.addr == dst_r) && (dmem_r.wdata == data_r) && $stable(n_r) && $stable(z_r))
    else $error("destination write wrong");

  chk_wreg_dest: assert property (
    ((state_r == dmi_pkg::ST_EXEC2) && (q_r == 2'h3) && (dst_r == 12'hFE0)) |=> (w_r == $past(data_r)))
    else $error("W as destination not written");

  chk_bank_load: assert property (
    (in_exec && (q_r == 2'h3) && (op_r == dmi_pkg::OP_LOAD_LITERAL_BANK_SELECT)) |=>
      (stat_o.bank_select_register == $past(lit_r[3:0])) && $stable(n_r) && $stable(z_r))
    else $error("bank select load wrong");

  chk_lit_working: assert property (
    (in_exec && (q_r == 2'h3) && (op_r == dmi_pkg::OP_LOAD_LITERAL_WORKING)) |=>
      (w_r == $past(lit_r)) && $stable(n_r) && $stable(z_r))
    else $error("literal to W wrong");

  chk_store_data: assert property (
    (in_exec && (q_r == 2'h2) && (op_r == dmi_pkg::OP_STORE_WORKING_TO_FILE) && (src_r != 12'hFE0)) |=>
      dmem_r.wr && (dmem_r.wdata == w_r) ##1 $stable(n_r) && $stable(z_r))
    else $error("store of W wrong");

  chk_banked_addr: assert property (
    ((state_r == dmi_pkg::ST_IDLE) && instr_valid_i && (instr_i[15:10] == 6'h14) && instr_i[8]) |=>
      (src_r == {$past(bsr_r), $past(instr_i[7:0])}))
    else $error("banked address wrong");

  chk_access_addr: assert property (
    ((state_r == dmi_pkg::ST_IDLE) && instr_valid_i && (instr_i[15:9] == 7'h37) && !instr_i[8] && !ext_en) |=>
      (src_r[7:0] == $past(instr_i[7:0])) && (src_r[11:8] == (src_r[7:0] < 8'h60 ? 4'h0 : 4'hF)))
    else $error("access bank address wrong");

  chk_indexed_addr: assert property (
    ((state_r == dmi_pkg::ST_IDLE) && instr_valid_i && (instr_i[15:10] == 6'h14) && !instr_i[8] && ext_en &&
     (instr_i[7:0] <= 8'h5F)) |=> (src_r == ($past(fsr2_i) + {4'h0, $past(instr_i[7:0])})))
    else $error("indexed address wrong");

endmodule : dmi_core

// [test/data_move_instruction_unit_tb.sv]
// Self-checking bench for the data-move instruction unit top, dmi_core.
// Assumes a byte data memory modelled here and the AHB-Lite register slave inside the core.
`timescale 1ns/1ps
`include "dmi_cfg.svh"

module data_move_instruction_unit_tb;
  // Clock, reset and instruction stream
  logic clk_i;
  logic arst_n_i;
  logic [15:0] instr_i;
  logic instr_valid_i;
  logic instr_ready_o;
  // Data memory, register file, status, bus
  dmi_pkg::dmi_dmem_req_t dmem_o;
  logic [7:0] dmem_rdata_i;
  logic [11:0] fsr2_i;
  dmi_pkg::dmi_stat_t stat_o;
  dmi_pkg::dmi_ahb_req_t ahb_q;
  dmi_pkg::dmi_ahb_req_t ahb_bus;
  dmi_pkg::dmi_ahb_rsp_t ahb_o;
  // Bench state
  logic [7:0] mem [0:4095];
  logic [31:0] rdat;
  int err_total;
  int n_compared;
  int rd_cnt = 0;
  int rd0;
  int busy_cyc;

  dmi_core dmi_core_i (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o),
    .dmem_o(dmem_o),
    .dmem_rdata_i(dmem_rdata_i),
    .fsr2_i(fsr2_i),
    .stat_o(stat_o),
    .ahb_i(ahb_bus),
    .ahb_o(ahb_o)
  );

  // 50 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Byte memory, one cycle read latency; idle data toggles so a late sample shows
  // Preload happens while reset is held, so memory and read data have one writer
  always @(posedge clk_i) begin
    if (!arst_n_i) begin
      dmem_rdata_i <= 8'h00;
      mem[12'h5C0] <= 8'h80;
      mem[12'h021] <= 8'h00;
      mem[12'h123] <= 8'h33;
      mem[12'h340] <= 8'h00;
    end else begin
      if (dmem_o.wr === 1'b1) mem[dmem_o.addr] <= dmem_o.wdata;
      if (dmem_o.rd === 1'b1) begin
        dmem_rdata_i <= mem[dmem_o.addr];
        rd_cnt <= rd_cnt + 1;
      end else begin
        dmem_rdata_i <= ~dmem_rdata_i;
      end
    end
  end

  // Single slave: its ready is the bus ready; the tasks drive only ahb_q
  always_comb begin
    ahb_bus = ahb_q;
    ahb_bus.hready = ahb_o.hreadyout;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offer one word, hold it until taken, then count cycles with ready low
  task automatic issue(input logic [15:0] word);
    int n;
    n = 0;
    @(posedge clk_i);
    instr_i <= word;
    instr_valid_i <= 1'b1;
    @(negedge clk_i);
    while (instr_ready_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    busy_cyc = 0;
    @(negedge clk_i);
    while (instr_ready_o === 1'b0 && busy_cyc < 50) begin
      @(negedge clk_i);
      busy_cyc++;
    end
    // A wait that runs out is a mismatch, not a silent pass
    if (n >= 50 || busy_cyc >= 50) begin
      err_total++;
      $display("CHECK FAILED instruction handshake expected under 50 cycles seen %0d", n + busy_cyc);
    end
  endtask : issue

  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdat,
                          output logic [31:0] rd);
    @(posedge clk_i);
    ahb_q.hsel <= 1'b1;
    ahb_q.htrans <= 2'b10;
    ahb_q.haddr <= addr;
    ahb_q.hwrite <= wr;
    ahb_q.hsize <= 3'b010;
    do @(posedge clk_i); while (ahb_o.hreadyout !== 1'b1);
    ahb_q.hsel <= 1'b0;
    ahb_q.htrans <= 2'b00;
    ahb_q.hwdata <= wdat;
    do @(posedge clk_i); while (ahb_o.hreadyout !== 1'b1);
    rd = ahb_o.hrdata;
    chk("bus response", 32'h0, ahb_o.hresp);
  endtask : ahb_xfer

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the under two hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    arst_n_i = 1'b0;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    fsr2_i = 12'h300;
    ahb_q = '0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    chk("ready at reset", 32'h1, instr_ready_o);
    chk("stat at reset", 32'h0, stat_o);
    ahb_xfer(1'b0, `DMI_REG_CTRL, 32'h0, rdat);
    chk("ctrl at reset", 32'h0, rdat);
    // Literal loads, flags left alone
    issue(16'h0E5A);
    chk("ready low cycles", 32'd4, busy_cyc);
    chk("w literal", 32'h5A, stat_o.w);
    issue(16'h01F5);
    ahb_xfer(1'b0, `DMI_REG_BANK, 32'h0, rdat);
    chk("bank select", 32'h5, rdat);
    // Banked read into W, negative value
    rd0 = rd_cnt;
    issue(16'h51C0);
    chk("w from file", 32'h80, stat_o.w);
    chk("flags n", 32'h2, {stat_o.flag_n, stat_o.flag_z});
    chk("reads per move", 32'h1, rd_cnt - rd0);
    ahb_xfer(1'b0, `DMI_REG_STAT, 32'h0, rdat);
    chk("stat reg", 32'h2, rdat);
    issue(16'h0E5A);
    chk("flags kept literal", 32'h2, {stat_o.flag_n, stat_o.flag_z});
    issue(16'h01F5);
    chk("flags kept bank", 32'h2, {stat_o.flag_n, stat_o.flag_z});
    // Stores through bank select and access bank, both halves
    issue(16'h6FFF);
    chk("banked store", 32'h5A, mem[12'h5FF]);
    issue(16'h6E20);
    chk("access low", 32'h5A, mem[12'h020]);
    issue(16'h6E80);
    chk("access high", 32'h5A, mem[12'hF80]);
    chk("flags kept store", 32'h2, {stat_o.flag_n, stat_o.flag_z});
    // Write back to file, zero value, W untouched
    issue(16'h5221);
    chk("w kept", 32'h5A, stat_o.w);
    chk("file kept", 32'h00, mem[12'h021]);
    chk("flags z", 32'h1, {stat_o.flag_n, stat_o.flag_z});
    // Indexed literal offset at its boundary
    ahb_xfer(1'b1, `DMI_REG_CTRL, 32'h1, rdat);
    ahb_xfer(1'b0, `DMI_REG_CTRL, 32'h0, rdat);
    chk("ctrl readback", 32'h1, rdat);
    issue(16'h6E5F);
    chk("indexed store", 32'h5A, mem[12'h35F]);
    issue(16'h6E60);
    chk("past index", 32'h5A, mem[12'hF60]);
    // Indexed read into W; a plain access-bank read would see an unset byte
    issue(16'h5040);
    chk("indexed read", 32'h00, stat_o.w);
    // File-to-file moves: one source read, flags kept, W as destination and as source
    rd0 = rd_cnt;
    issue(16'hC123);
    issue(16'hF456);
    chk("second word cycles", 32'd4, busy_cyc);
    chk("reads file move", 32'h1, rd_cnt - rd0);
    chk("file to file", 32'h33, mem[12'h456]);
    chk("flags kept move", 32'h1, {stat_o.flag_n, stat_o.flag_z});
    issue(16'hC456);
    issue(16'hFFE0);
    chk("move into w", 32'h33, stat_o.w);
    issue(16'hCFE0);
    issue(16'hF789);
    chk("move from w", 32'h33, mem[12'h789]);
    // Foreign opcode is dropped without a busy spell
    issue(16'h0D12);
    chk("foreign busy", 32'h0, busy_cyc);
    chk("foreign w", 32'h33, stat_o.w);
    // Second word without its prefix drops the move and is not executed
    issue(16'hC123);
    issue(16'h0E77);
    chk("dropped move busy", 32'h0, busy_cyc);
    chk("dropped move w", 32'h33, stat_o.w);
    // Read-only and unmapped places
    ahb_xfer(1'b1, `DMI_REG_WREG, 32'hFF, rdat);
    ahb_xfer(1'b0, `DMI_REG_WREG, 32'h0, rdat);
    chk("wreg read only", 32'h33, rdat);
    ahb_xfer(1'b0, 32'h00000040, 32'h0, rdat);
    chk("unmapped", 32'h0, rdat);
    end_of_test();
  end
endmodule : data_move_instruction_unit_tb
